// *** inc/hpp_consts.svh ***
// Purpose: register offsets, field positions and reset values of the host parallel port
// Assumes: byte addresses on a 12-bit APB address, one 32-bit word per register
// Notes:   included by the top module and by the bench
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH

// register byte offsets
`define HPP_OFF_DATA_PORT   12'h000
`define HPP_OFF_DATA_LATCH  12'h004
`define HPP_OFF_DATA_DIR    12'h008
`define HPP_OFF_PIN_E       12'h00c
`define HPP_OFF_LATCH_E     12'h010
`define HPP_OFF_CTRL        12'h014
`define HPP_OFF_ANALOG      12'h018
`define HPP_OFF_IRQ         12'h01c

// fields of direction_and_host_port_control
`define HPP_BIT_IN_FULL     7
`define HPP_BIT_OUT_FULL    6
`define HPP_BIT_IN_OVR      5
`define HPP_BIT_MODE        4
`define HPP_BIT_UNUSED      3

// fields of the host-port event register
`define HPP_BIT_IRQ_FLAG    0
`define HPP_BIT_IRQ_EN      1
`define HPP_BIT_IRQ_PRI     2

// port-E pin roles in host-port mode
`define HPP_PIN_RD          0
`define HPP_PIN_WR          1
`define HPP_PIN_CS          2

// reset values and all-input/all-output enable patterns
`define HPP_RST_DATA_DIR    8'hff
`define HPP_RST_LATCH_D     8'h00
`define HPP_RST_DIR_E       3'h7
`define HPP_RST_LATCH_E     3'h0
`define HPP_RST_ANALOG      3'h0
`define HPP_RST_OE_D        8'hff
`define HPP_RST_OE_E        3'h7
`define HPP_ALL_IN_D        8'hff
`define HPP_ALL_OUT_D       8'h00
`define HPP_ALL_IN_E        3'h7

`endif

// *** inc/hpp_pkg.sv ***
// Purpose: types shared by the host parallel port files
// Assumes: hpp_consts.svh holds the numbers
// Notes:   the whole top-level state is one packed struct
package hpp_pkg;

  typedef enum logic [1:0] {
    hpp_idle,
    hpp_write,
    hpp_read
  } hpp_state_t;

  typedef struct packed {
    hpp_state_t  state;
    logic [7:0]  data_latch;
    logic [7:0]  data_in;
    logic [7:0]  data_dir;
    logic [2:0]  latch_e;
    logic [2:0]  dir_e;
    logic        mode;
    logic        in_full;
    logic        out_full;
    logic        in_ovr;
    logic [2:0]  analog_cfg;
    logic        irq_flag;
    logic        irq_en;
    logic        irq_pri;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  pd_out;
    logic [7:0]  pd_oe_n;
    logic [2:0]  pe_out;
    logic [2:0]  pe_oe_n;
  } hpp_regs_t;

endpackage

// *** design/hpp_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes:   only the second stage is visible outside
`timescale 1ns/1ns
module hpp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;

endmodule // hpp_sync

// *** design/hpp_edge.sv ***
// Purpose: edge detector giving one-cycle start and end pulses
// Assumes: input already on the clock domain
// Notes:   previous value resets to inactive
`timescale 1ns/1ns
module hpp_edge #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= '0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

endmodule // hpp_edge

// *** design/hpp_port_e_host.sv ***
// Purpose: 3-bit port E and 8-bit host parallel port with APB register access
// Assumes: pins are asynchronous and pass two flops; APB master on clock
// Notes:   host strobes are seen two to three cycles late through the synchronisers
`timescale 1ns/1ns
`include "hpp_consts.svh"
module hpp_port_e_host
  import hpp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  pe_in,
  output logic      [2:0]  pe_out,
  output logic      [2:0]  pe_oe_n,
  input  wire logic [7:0]  pd_in,
  output logic      [7:0]  pd_out,
  output logic      [7:0]  pd_oe_n,
  output logic             host_port_irq_flag
);

  localparam hpp_regs_t RST_C = '{
    state:      hpp_idle,
    data_latch: `HPP_RST_LATCH_D,
    data_dir:   `HPP_RST_DATA_DIR,
    latch_e:    `HPP_RST_LATCH_E,
    dir_e:      `HPP_RST_DIR_E,
    analog_cfg: `HPP_RST_ANALOG,
    pd_oe_n:    `HPP_RST_OE_D,
    pe_oe_n:    `HPP_RST_OE_E,
    default:    '0
  };

  hpp_regs_t   r;
  hpp_regs_t   n;
  logic [2:0]  pe_s;
  logic [7:0]  pd_s;
  logic [1:0]  act;
  logic [1:0]  act_rise;
  logic [1:0]  act_fall;
  logic        wr_act;
  logic        rd_act;
  logic        setup;
  logic        access;
  logic        hit;
  logic [31:0] rd_val;
  logic        cpu_wr;
  logic        cpu_dp_wr;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and strobe edges

  hpp_sync #(.W(3)) u_sync_e (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (pe_in),
    .dout   (pe_s)
  );

  hpp_sync #(.W(8)) u_sync_d (
    .clock  (clock),
    .arst_n (arst_n),
    .din    (pd_in),
    .dout   (pd_s)
  );

  assign wr_act = r.mode & ~pe_s[`HPP_PIN_CS] & ~pe_s[`HPP_PIN_WR];
  assign rd_act = r.mode & ~pe_s[`HPP_PIN_CS] & ~pe_s[`HPP_PIN_RD];
  assign act    = {rd_act, wr_act};

  hpp_edge #(.W(2)) u_edge (
    .clock  (clock),
    .arst_n (arst_n),
    .level  (act),
    .rise   (act_rise),
    .fall   (act_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb decode and read mux

  assign setup     = psel & ~penable;
  // pready from a flop limits each setup to exactly one access edge
  assign access    = psel & penable & r.pready;
  assign cpu_wr    = access & pwrite & pstrb[0] & hit;
  assign cpu_dp_wr = cpu_wr & (paddr == `HPP_OFF_DATA_PORT);

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `HPP_OFF_DATA_PORT:  rd_val[7:0] = r.mode ? r.data_in : pd_s;
      `HPP_OFF_DATA_LATCH: rd_val[7:0] = r.data_latch;
      `HPP_OFF_DATA_DIR:   rd_val[7:0] = r.data_dir;
      `HPP_OFF_PIN_E:      rd_val[2:0] = pe_s & r.analog_cfg;
      `HPP_OFF_LATCH_E:    rd_val[2:0] = r.latch_e;
      `HPP_OFF_CTRL:       rd_val[7:0] = {r.in_full, r.out_full, r.in_ovr, r.mode, 1'b0, r.dir_e};
      `HPP_OFF_ANALOG:     rd_val[2:0] = r.analog_cfg;
      `HPP_OFF_IRQ:        rd_val[2:0] = {r.irq_pri, r.irq_en, r.irq_flag};
      default:             hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n         = r;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    // one wait-free access phase: answer prepared during setup
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = ~hit;
      n.prdata  = pwrite ? 32'h0000_0000 : rd_val;
    end
    if (access && !pwrite && paddr == `HPP_OFF_DATA_PORT && r.mode) begin
      n.in_full = 1'b0;
    end
    if (cpu_wr) begin
      case (paddr)
        `HPP_OFF_DATA_PORT:  n.data_latch = pwdata[7:0];
        `HPP_OFF_DATA_LATCH: n.data_latch = pwdata[7:0];
        `HPP_OFF_DATA_DIR:   n.data_dir = pwdata[7:0];
        `HPP_OFF_PIN_E:      n.latch_e = pwdata[2:0];
        `HPP_OFF_LATCH_E:    n.latch_e = pwdata[2:0];
        `HPP_OFF_CTRL: begin
          n.mode  = pwdata[`HPP_BIT_MODE];
          n.in_ovr = pwdata[`HPP_BIT_IN_OVR];
          n.dir_e = pwdata[2:0];
        end
        `HPP_OFF_ANALOG:     n.analog_cfg = pwdata[2:0];
        `HPP_OFF_IRQ: begin
          n.irq_flag = r.irq_flag & pwdata[`HPP_BIT_IRQ_FLAG];
          n.irq_en   = pwdata[`HPP_BIT_IRQ_EN];
          n.irq_pri  = pwdata[`HPP_BIT_IRQ_PRI];
        end
        default:             n.data_dir = r.data_dir;
      endcase
    end
    // host sequencer comes after software so hardware sets win
    unique case (r.state)
      hpp_idle: begin
        if (act_rise[0]) begin
          n.state   = hpp_write;
          n.data_in = pd_s;
          if (r.in_full) begin
            n.in_ovr = 1'b1;
          end
        end else if (act_rise[1]) begin
          n.state = hpp_read;
        end
      end
      hpp_write: begin
        if (wr_act) begin
          n.data_in = pd_s;
        end else begin
          n.state    = hpp_idle;
          n.in_full  = 1'b1;
          n.irq_flag = 1'b1;
        end
      end
      hpp_read: begin
        if (!rd_act) begin
          n.state    = hpp_idle;
          n.out_full = 1'b0;
          n.irq_flag = 1'b1;
        end
      end
      // code 3 is never loaded; fall back rather than lock the sequencer
      default: begin
        n.state = hpp_idle;
      end
    endcase
    if (cpu_dp_wr && n.mode) begin
      n.out_full = 1'b1;
    end
    n.pd_out = n.data_latch;
    // in host-port mode drive only during read; otherwise drive follows data_dir
    // drive follows the synced strobe, so it lags the pin by about three clocks
    if (r.mode) begin
      n.pd_oe_n = rd_act ? `HPP_ALL_OUT_D : `HPP_ALL_IN_D;
    end else begin
      n.pd_oe_n = n.data_dir;
    end
    n.pe_out  = n.latch_e;
    n.pe_oe_n = n.mode ? `HPP_ALL_IN_E : n.dir_e;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r <= RST_C;
    end else begin
      r <= n;
    end
  end

  assign prdata             = r.prdata;
  assign pready             = r.pready;
  assign pslverr            = r.pslverr;
  assign pe_out             = r.pe_out;
  assign pe_oe_n            = r.pe_oe_n;
  assign pd_out             = r.pd_out;
  assign pd_oe_n            = r.pd_oe_n;
  assign host_port_irq_flag = r.irq_flag;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_DIR_DRIVE: assert property (
    (!r.mode && !$past(n.mode)) |-> (pe_oe_n == r.dir_e && pe_out == r.latch_e))
    else $error("port E drive does not follow direction and latch");
  AST_LATCH_READ: assert property (
    (setup && !pwrite && paddr == `HPP_OFF_LATCH_E) |=> prdata[2:0] == $past(r.latch_e))
    else $error("latch read did not return latch");
  AST_ANALOG_ZERO: assert property (
    (setup && !pwrite && paddr == `HPP_OFF_PIN_E && r.analog_cfg == 3'h0) |=> prdata == 32'h0)
    else $error("analog pins did not read zero");
  AST_IN_FULL_SET: assert property (
    (r.state == hpp_write && !wr_act) |=> (r.in_full && r.irq_flag && r.state == hpp_idle))
    else $error("host write completion did not set input full");
  AST_OUT_FULL_CLR: assert property (
    (r.state == hpp_read && !rd_act && !cpu_dp_wr) |=> !r.out_full)
    else $error("host read completion did not clear output full");
  AST_OVERFLOW: assert property (
    (r.state == hpp_idle && act_rise[0] && r.in_full) |=> r.in_ovr)
    else $error("rewrite of unread word did not set overflow");
  AST_BIT3_ZERO: assert property (
    (setup && !pwrite && paddr == `HPP_OFF_CTRL) |=> (prdata[3] == 1'b0 && pready))
    else $error("control bit 3 read as one");
  AST_HOST_INPUTS: assert property (
    $past(n.mode) |-> pe_oe_n == `HPP_ALL_IN_E)
    else $error("port E driven in host-port mode");
  AST_NO_STROBE: assert property (
    (r.mode && pe_s[`HPP_PIN_CS] && r.state == hpp_idle) |=> r.state == hpp_idle)
    else $error("transfer started while deselected");
  AST_RD_DRIVE: assert property (
    (r.mode && $past(r.mode) && pd_oe_n != `HPP_ALL_IN_D) |-> $past(rd_act))
    else $error("data pins driven outside a host read");

  // software-side register effects
  AST_MODE_WRITE: assert property (
    (cpu_wr && paddr == `HPP_OFF_CTRL) |=> r.mode == $past(pwdata[`HPP_BIT_MODE]))
    else $error("mode bit did not take the written value");
  AST_OVR_CLEAR: assert property (
    (cpu_wr && paddr == `HPP_OFF_CTRL && !pwdata[`HPP_BIT_IN_OVR]
     && !(r.state == hpp_idle && act_rise[0] && r.in_full)) |=> !r.in_ovr)
    else $error("software clear of overflow was lost");
  AST_LATCH_WRITE: assert property (
    (cpu_wr && (paddr == `HPP_OFF_LATCH_E || paddr == `HPP_OFF_PIN_E)) |=> r.latch_e == $past(pwdata[2:0]))
    else $error("port E latch did not take the written value");
  AST_ANALOG_MASK: assert property (
    (setup && !pwrite && paddr == `HPP_OFF_PIN_E) |=> (prdata[2:0] & ~$past(r.analog_cfg)) == 3'h0)
    else $error("analog pin read back as one");
  AST_DATA_PORT_WRITE: assert property (
    (cpu_wr && paddr == `HPP_OFF_DATA_PORT) |=> r.data_latch == $past(pwdata[7:0]))
    else $error("data port write did not reach the data latch");
  AST_DATA_PORT_GPIO: assert property (
    (setup && !pwrite && paddr == `HPP_OFF_DATA_PORT && !r.mode) |=> prdata[7:0] == $past(pd_s))
    else $error("data port read did not return the pins");
  AST_OUT_FULL_SET: assert property (
    (cpu_dp_wr && r.mode) |=> r.out_full)
    else $error("cpu data write did not set output full");
  AST_IN_FULL_CLR: assert property (
    (access && !pwrite && paddr == `HPP_OFF_DATA_PORT && r.mode && !(r.state == hpp_write && !wr_act))
    |=> !r.in_full)
    else $error("cpu data read did not clear input full");
  AST_IRQ_CLEAR: assert property (
    (cpu_wr && paddr == `HPP_OFF_IRQ && !pwdata[`HPP_BIT_IRQ_FLAG] && r.state == hpp_idle) |=> !r.irq_flag)
    else $error("event flag did not clear");
  AST_GPIO_PD_DIR: assert property (
    $past(!r.mode) |-> pd_oe_n == r.data_dir)
    else $error("data port drive does not follow direction");

  // host-side sequencing
  AST_WRITE_START: assert property (
    (r.state == hpp_idle && act_rise[0]) |=> r.state == hpp_write)
    else $error("host write did not start");
  AST_READ_START: assert property (
    (r.state == hpp_idle && act_rise[1] && !act_rise[0]) |=> r.state == hpp_read)
    else $error("host read did not start");
  AST_WRITE_CAPTURE: assert property (
    (r.state == hpp_write && wr_act) |=> r.data_in == $past(pd_s))
    else $error("host write data not captured");
  AST_READ_DRIVE: assert property (
    ($past(r.mode) && $past(rd_act)) |-> (pd_oe_n == `HPP_ALL_OUT_D && pd_out == r.data_latch))
    else $error("host read did not present the data latch");
  AST_GPIO_NO_XFER: assert property (
    (!r.mode && r.state == hpp_idle) |=> r.state == hpp_idle)
    else $error("host transfer started in general-purpose mode");

  COV_HOST_WRITE: cover property (r.state == hpp_write ##[1:20] r.in_full);
  COV_HOST_READ: cover property (r.state == hpp_read ##[1:20] r.state == hpp_idle);
  COV_OVERFLOW: cover property ($rose(r.in_ovr));
  COV_UNMAPPED: cover property (pready && pslverr);
  COV_HOST_DRIVE: cover property (r.mode && pd_oe_n == `HPP_ALL_OUT_D);

endmodule // hpp_port_e_host

// *** test/hpp_host_model.sv ***
// Purpose: external 8-bit bus master driving the host-port strobes and data pins
// Assumes: strobes bit0 read, bit1 write, bit2 select, all active low
// Notes:   a released data bus shows the inverse of its last value, never a kind constant
`timescale 1ns/1ns
module hpp_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] pd_bus,
  output logic      [2:0] strobe_n,
  output logic      [7:0] pd_drv
);
  initial begin
    strobe_n = 3'h7;
    pd_drv   = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // select, strobe, data
  // hold is the strobe width in clocks; the gap afterwards covers data hold and idle
  task automatic xfer(input logic wr, input logic sel, input logic [7:0] d, input int hold,
                      output logic [7:0] q);
    @(posedge clock);
    if (wr) begin
      pd_drv <= d;
    end
    strobe_n <= {~sel, ~wr, wr};
    repeat (hold) @(posedge clock);
    q = pd_bus;
    strobe_n <= 3'h7;
    repeat (4) @(posedge clock);
    pd_drv <= ~pd_drv;
    repeat (2) @(posedge clock);
  endtask
endmodule // hpp_host_model

// *** test/hpp_port_e_host_bench.sv ***
// Purpose: self-checking bench for the port E and host parallel port block
// Assumes: APB with zero wait states; pins resolved from the block's enables alone, host drive elsewhere
// Notes:   pin reads wait a few clocks so the two-flop synchronisers settle
`timescale 1ns/1ns
`include "hpp_consts.svh"
module hpp_port_e_host_bench;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pe_in;
  logic [2:0]  pe_out;
  logic [2:0]  pe_oe_n;
  logic [7:0]  pd_in;
  logic [7:0]  pd_out;
  logic [7:0]  pd_oe_n;
  logic        irq;
  logic [2:0]  hpe;
  logic [7:0]  hpd;
  logic [7:0]  q;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          n_compared = 0;

  always #10 clock = ~clock;
  assign pe_in = (~pe_oe_n & pe_out) | (pe_oe_n & hpe);
  assign pd_in = (~pd_oe_n & pd_out) | (pd_oe_n & hpd);

  hpp_port_e_host hpp_port_e_host_i (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pe_in(pe_in), .pe_out(pe_out), .pe_oe_n(pe_oe_n), .pd_in(pd_in),
    .pd_out(pd_out), .pd_oe_n(pd_oe_n), .host_port_irq_flag(irq));
  hpp_host_model hpp_host_model_i (.clock(clock), .pd_bus(pd_in), .strobe_n(hpe), .pd_drv(hpd));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rchk("ctrl_rst", `HPP_OFF_CTRL, 32'h07);
    rchk("dir_d_rst", `HPP_OFF_DATA_DIR, 32'hff);
    rchk("pin_e_rst", `HPP_OFF_PIN_E, 32'h0);
    // software makes the pins digital first
    apb(1'b1, `HPP_OFF_ANALOG, 32'h7);
    apb(1'b1, `HPP_OFF_LATCH_E, 32'h5);
    apb(1'b1, `HPP_OFF_CTRL, 32'h0);
    repeat (4) @(posedge clock);
    chk("pe_oe_n", pe_oe_n, 3'h0);
    chk("pe_out", pe_out, 3'h5);
    rchk("pin_e_out", `HPP_OFF_PIN_E, 32'h5);
    apb(1'b1, `HPP_OFF_CTRL, 32'hcf);
    repeat (4) @(posedge clock);
    chk("pe_oe_n_in", pe_oe_n, 3'h7);
    rchk("ctrl_ro", `HPP_OFF_CTRL, 32'h07);
    rchk("pin_e_in", `HPP_OFF_PIN_E, 32'h7);
    rchk("latch_e", `HPP_OFF_LATCH_E, 32'h5);
    apb(1'b1, `HPP_OFF_ANALOG, 32'h5);
    rchk("pin_e_analog", `HPP_OFF_PIN_E, 32'h5);
    apb(1'b1, `HPP_OFF_ANALOG, 32'h7);
    apb(1'b1, `HPP_OFF_DATA_LATCH, 32'ha5);
    apb(1'b1, `HPP_OFF_DATA_DIR, 32'h0);
    repeat (4) @(posedge clock);
    chk("pd_oe_n_gpio", pd_oe_n, 8'h00);
    rchk("data_port_gpio", `HPP_OFF_DATA_PORT, 32'ha5);
    apb(1'b1, `HPP_OFF_DATA_DIR, 32'hff);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    // a write with byte strobe 0 clear is ignored
    pstrb <= 4'h0;
    apb(1'b1, `HPP_OFF_DATA_LATCH, 32'h3c);
    pstrb <= 4'hf;
    rchk("strb_off", `HPP_OFF_DATA_LATCH, 32'ha5);
    // host-port mode: two host writes, the first one unread
    apb(1'b1, `HPP_OFF_CTRL, 32'h17);
    hpp_host_model_i.xfer(1'b1, 1'b1, 8'h3c, 4, q);
    rchk("ctrl_in_full", `HPP_OFF_CTRL, 32'h97);
    chk("irq_wr", irq, 32'h1);
    hpp_host_model_i.xfer(1'b1, 1'b1, 8'hc3, 8, q);
    rchk("ctrl_in_ovr", `HPP_OFF_CTRL, 32'hb7);
    rchk("data_in", `HPP_OFF_DATA_PORT, 32'hc3);
    rchk("ctrl_in_full_clr", `HPP_OFF_CTRL, 32'h37);
    apb(1'b1, `HPP_OFF_CTRL, 32'h17);
    rchk("ctrl_in_ovr_clr", `HPP_OFF_CTRL, 32'h17);
    apb(1'b1, `HPP_OFF_IRQ, 32'h0);
    // the clear lands at the access edge; look one edge later
    @(posedge clock);
    chk("irq_clr", irq, 32'h0);
    // host read of a word the CPU wrote
    apb(1'b1, `HPP_OFF_DATA_PORT, 32'h5a);
    rchk("ctrl_out_full", `HPP_OFF_CTRL, 32'h57);
    chk("pd_oe_n_idle", pd_oe_n, 8'hff);
    hpp_host_model_i.xfer(1'b0, 1'b1, 8'h00, 5, q);
    chk("host_read", q, 8'h5a);
    chk("pd_oe_n_after", pd_oe_n, 8'hff);
    rchk("ctrl_out_full_clr", `HPP_OFF_CTRL, 32'h17);
    chk("irq_rd", irq, 32'h1);
    apb(1'b1, `HPP_OFF_IRQ, 32'h0);
    // strobes with select high do nothing
    hpp_host_model_i.xfer(1'b1, 1'b0, 8'h99, 5, q);
    rchk("ctrl_nosel", `HPP_OFF_CTRL, 32'h17);
    chk("irq_nosel", irq, 32'h0);
    chk("pe_oe_n_host", pe_oe_n, 3'h7);
    end_sim();
  end
endmodule // hpp_port_e_host_bench
